//--- txsi_defines.vh
// Register indices, field positions, reset values and timing counts of the tx status block
`ifndef TXSI_DEFINES_VH
`define TXSI_DEFINES_VH

// Register indices; byte address is four times the index
`define TXSI_IDX_WMARK 10'h187
`define TXSI_IDX_SYNCC 10'h18e
`define TXSI_IDX_LS1 10'h190
`define TXSI_IDX_LS2 10'h191
`define TXSI_IDX_LS3 10'h192
`define TXSI_IDX_SUM 10'h19f
`define TXSI_IDX_MASK1 10'h1a0
`define TXSI_IDX_MASK2 10'h1a1
`define TXSI_IDX_MASK3 10'h1a2
`define TXSI_IDX_MODE 10'h1f0
`define TXSI_RESET_VAL 8'h00

// Sync control fields
`define TXSI_SYNC_RESYNC 0
`define TXSI_SYNC_NOAUTO 1
`define TXSI_SYNC_EN 2
`define TXSI_SYNC_CRC4 3
`define TXSI_SYNC_W 4

// Mode register fields
`define TXSI_MODE_E1 0
`define TXSI_MODE_ESF 1
`define TXSI_MODE_LOOPMF 2
`define TXSI_MODE_ALARM_EN 3
`define TXSI_MODE_W 4

// Framing status bit positions
`define TXSI_LS1_FULL 7
`define TXSI_LS1_EMPTY 6
`define TXSI_LS1_SLIP 5
`define TXSI_LS1_LOOPMF 4
`define TXSI_LS1_ALIGN 3
`define TXSI_LS1_MF 2
`define TXSI_LS1_CLKOK 1
`define TXSI_LS1_CLKLOST 0

// Hdlc status bit positions
`define TXSI_LS2_DLEMPTY 4
`define TXSI_LS2_UNDERRUN 3
`define TXSI_LS2_MSGEND 2
`define TXSI_LS2_BELOWWM 1
`define TXSI_LS2_NOTFULL 0
`define TXSI_LS2_USED 8'h1f

// Synchronizer status bit positions
`define TXSI_LS3_HUNT_NOW 1
`define TXSI_LS3_LOST 0

// Hdlc fifo depth and watermarks in bytes
`define TXSI_FIFO_DEPTH 7'h40
`define TXSI_WM_0 7'h04
`define TXSI_WM_1 7'h10
`define TXSI_WM_2 7'h20
`define TXSI_WM_3 7'h30

// Timing: frame period and event periods in ns, frame counts derived
`define TXSI_FRAME_NS 125000
`define TXSI_ALIGN_NS 250000
`define TXSI_D4_MF_NS 1500000
`define TXSI_ESF_MF_NS 3000000
`define TXSI_E1_MF_NS 2000000
`define TXSI_LOOPMF_FRAMES 72
`define TXSI_ALIGN_FRAMES (`TXSI_ALIGN_NS / `TXSI_FRAME_NS)
`define TXSI_D4_FRAMES (`TXSI_D4_MF_NS / `TXSI_FRAME_NS)
`define TXSI_ESF_FRAMES (`TXSI_ESF_MF_NS / `TXSI_FRAME_NS)
`define TXSI_E1_FRAMES (`TXSI_E1_MF_NS / `TXSI_FRAME_NS)

// Loss of tx clock: three periods of the slowest line clock, rounded up
`define TXSI_PCLK_NS 10
`define TXSI_TCLK_PERIOD_NS 648
`define TXSI_LOST_PERIODS 3
`define TXSI_LOST_CYCLES ((`TXSI_LOST_PERIODS * `TXSI_TCLK_PERIOD_NS + `TXSI_PCLK_NS - 1) / `TXSI_PCLK_NS)

`endif

//--- txsi_event_latch.v
// Eight sticky event flags with write-one-to-clear, set winning over clear
`default_nettype none

module txsi_event_latch (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Event and clear strobes per bit
	input wire [7:0] set,
	input wire [7:0] clr,
	// Latched flags
	output wire [7:0] flag
);

	genvar i;

	// One flop per flag; a set in the clearing cycle is kept
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_bit
			reg held;
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					held <= 1'b0;
				else if (set[i])
					held <= 1'b1;
				else if (clr[i])
					held <= 1'b0;
			end
			assign flag[i] = held;
		end
	endgenerate

endmodule

`default_nettype wire

//--- txsi_clock_monitor.v
// Watches the sampled tx clock pin for missing transitions
`default_nettype none
`include "txsi_defines.vh"

module txsi_clock_monitor (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Sampled tx clock pin
	input wire tx_clock_input,
	// Status
	output reg lost,
	output wire lost_rise,
	output wire restored
);

	// Count kept at 8 bits; the limit is well below 256
	localparam integer LIMIT_I = `TXSI_LOST_CYCLES;
	localparam [7:0] LIMIT = LIMIT_I[7:0];

	reg last;
	reg [7:0] quiet;
	wire edge_seen;

	assign edge_seen = tx_clock_input ^ last;
	// Pulses on entry to and exit from the lost state
	assign lost_rise = !lost && !edge_seen && (quiet == LIMIT - 8'h01);
	assign restored = lost && edge_seen;

	// Count cycles since the last transition; any edge restarts the count
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last <= 1'b0;
			quiet <= 8'h00;
			lost <= 1'b0;
		end
		else
		begin
			last <= tx_clock_input;
			if (edge_seen)
			begin
				quiet <= 8'h00;
				lost <= 1'b0;
			end
			else if (quiet != LIMIT)
			begin
				quiet <= quiet + 8'h01;
				if (quiet == LIMIT - 8'h01)
					lost <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

//--- txsi_top.v
// Transmit-side status, mask and interrupt logic of one framer port, APB slave
//
// Contract
// R1: Sync control bit 0 allows automatic resync; 1 suppresses it.
// R2: Resync bit rising edge starts one resync; software clears and resets to repeat.
// R3: Store-full flag bit 7 latches when the elastic store drops a frame.
// R4: Store-empty flag bit 6 latches when the elastic store repeats a frame.
// R5: Slip flag bit 5 latches on any drop or repeat.
// R6: T1 loop multiframe flag bit 4 latches every 72 frames when enabled.
// R7: E1 align-frame flag bit 3 latches every 250 us.
// R8: Multiframe flag latches every 1.5 ms D4, 3 ms ESF, 2 ms E1.
// R9: Clock-restored flag bit 1 latches when tx clock activity returns.
// R10: Clock-lost flag latches after about 3 quiet periods; alarm pin if enabled.
// R11: Alarm pin stays high while clock absent even if flag cleared.
// R12: Unmasked clock-lost flag pulls interrupt low; clear releases if nothing else.
// R13: T1 data-link-empty flag bit 4 latches when link register shifted out.
// R14: Fifo empty before message end latches underrun and sends an abort.
// R15: Message-end flag bit 2 latches when a message completes.
// R16: Below-watermark flag latches on rising edge of below-watermark condition.
// R17: Not-full flag latches on rising edge of not-full condition.
// R18: While hunting, bit 1 reads 1 live and latched bit 0 sets.
// R19: Summary bits 0..2 show which status register has unmasked pending flags.
// R20: Mask bit 1 passes its flag to the interrupt, 0 blocks; reset 0.
// R21: Framing and hdlc flags all sticky; synchronizer register mixes kinds.
// R22: Watermark select 00..11 gives 4, 16, 32, 48 bytes.
// R23: Synchronizer and its loss reporting work only when enabled.
// R24: Flags stay until cleared; interrupt is OR of unmasked flags.
// R25: T1-only or E1-only flags never set in the other mode.
//
// Our own choice: register access over APB.
`default_nettype none
`include "txsi_defines.vh"

module txsi_top (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	// Elastic store events
	input wire store_drop,
	input wire store_repeat,
	// Frame timing, one pulse per transmitted frame
	input wire frame_pulse,
	// Tx clock pin, taken as synchronous
	input wire tx_clock_input,
	// Data link and hdlc fifo
	input wire data_link_shift_done,
	input wire [6:0] fifo_level,
	input wire message_open,
	input wire message_done,
	// Synchronizer datapath
	input wire sync_searching,
	// Synchronizer control outputs
	output wire tx_synchronizer_enable,
	output wire auto_resync_enable,
	output reg resync_start,
	output wire crc4_search,
	// Hdlc abort request
	output reg abort_send,
	// Alarm and interrupt pins
	output wire tx_clock_lost,
	output wire irq_out_n_o,
	output wire irq_out_n_oe
);

	// Software-written control state
	reg [1:0] watermark_select;
	reg [`TXSI_SYNC_W-1:0] sync_ctl;
	reg [`TXSI_MODE_W-1:0] mode_ctl;
	reg [7:0] tx_mask_framing;
	reg [7:0] tx_mask_hdlc;
	reg [7:0] tx_mask_synchronizer;

	// Event history
	reg resync_prev;
	reg below_prev;
	reg not_full_prev;
	reg fifo_was_empty;
	reg [6:0] frame_count;

	// Decoded access
	wire [9:0] idx;
	wire wr;
	wire setup;
	wire mapped;
	wire e1_mode;
	wire esf_mode;
	wire auto_resync_disable;
	wire clk_lost_level;
	wire clk_lost_rise;
	wire clk_restored;
	wire below_watermark_now;
	wire not_full_now;
	wire sync_hunting_now;
	wire underrun;
	wire [6:0] threshold;
	wire [6:0] frame_wrap;
	wire frame_last;
	wire align_due;
	wire mf_due;
	wire [7:0] set_ls1;
	wire [7:0] set_ls2;
	wire [7:0] set_ls3;
	wire [7:0] clr_ls1;
	wire [7:0] clr_ls2;
	wire [7:0] clr_ls3;
	wire [7:0] tx_latched_status_framing;
	wire [7:0] tx_latched_status_hdlc;
	wire [7:0] ls3_latched;
	wire [7:0] tx_status_synchronizer;
	wire [7:0] tx_interrupt_summary;
	reg [7:0] next_read;

	// Frame periods as 7-bit constants; every period fits below 128 frames
	localparam integer ALIGN_I = `TXSI_ALIGN_FRAMES;
	localparam integer D4_I = `TXSI_D4_FRAMES;
	localparam integer ESF_I = `TXSI_ESF_FRAMES;
	localparam integer E1_I = `TXSI_E1_FRAMES;
	localparam integer LOOP_I = `TXSI_LOOPMF_FRAMES;
	localparam [6:0] ALIGN_N = ALIGN_I[6:0];
	localparam [6:0] D4_N = D4_I[6:0];
	localparam [6:0] ESF_N = ESF_I[6:0];
	localparam [6:0] E1_N = E1_I[6:0];
	localparam [6:0] LOOP_N = LOOP_I[6:0];

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;

	assign e1_mode = mode_ctl[`TXSI_MODE_E1];
	assign esf_mode = mode_ctl[`TXSI_MODE_ESF];
	assign auto_resync_disable = sync_ctl[`TXSI_SYNC_NOAUTO];
	assign tx_synchronizer_enable = sync_ctl[`TXSI_SYNC_EN];
	assign crc4_search = sync_ctl[`TXSI_SYNC_CRC4] && e1_mode;

	// Auto resync only when the synchronizer runs and software has not blocked it
	assign auto_resync_enable = tx_synchronizer_enable && !auto_resync_disable; // R1 R23

	// Address map check; unmapped indices answer with an error
	assign mapped = (idx == `TXSI_IDX_WMARK) || (idx == `TXSI_IDX_SYNCC) ||
		(idx == `TXSI_IDX_LS1) || (idx == `TXSI_IDX_LS2) || (idx == `TXSI_IDX_LS3) ||
		(idx == `TXSI_IDX_SUM) || (idx == `TXSI_IDX_MASK1) || (idx == `TXSI_IDX_MASK2) ||
		(idx == `TXSI_IDX_MASK3) || (idx == `TXSI_IDX_MODE);

	// Control registers, written at the access edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			watermark_select <= 2'h0;
			sync_ctl <= 4'h0;
			mode_ctl <= 4'h0;
			tx_mask_framing <= `TXSI_RESET_VAL; // R20
			tx_mask_hdlc <= `TXSI_RESET_VAL; // R20
			tx_mask_synchronizer <= `TXSI_RESET_VAL; // R20
		end
		else if (wr)
		begin
			if (idx == `TXSI_IDX_WMARK)
				watermark_select <= pwdata[1:0];
			else if (idx == `TXSI_IDX_SYNCC)
				sync_ctl <= pwdata[`TXSI_SYNC_W-1:0];
			else if (idx == `TXSI_IDX_MODE)
				mode_ctl <= pwdata[`TXSI_MODE_W-1:0];
			else if (idx == `TXSI_IDX_MASK1)
				tx_mask_framing <= pwdata[7:0];
			else if (idx == `TXSI_IDX_MASK2)
				tx_mask_hdlc <= pwdata[7:0] & `TXSI_LS2_USED;
			else if (idx == `TXSI_IDX_MASK3)
				tx_mask_synchronizer <= {7'h00, pwdata[0]};
		end
	end

	// Resync request: only a low-to-high change of the bit counts
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resync_prev <= 1'b0;
			resync_start <= 1'b0;
		end
		else
		begin
			resync_prev <= sync_ctl[`TXSI_SYNC_RESYNC];
			resync_start <= sync_ctl[`TXSI_SYNC_RESYNC] && !resync_prev &&
				tx_synchronizer_enable; // R2 R23
		end
	end

	// Frame counter; wraps at the longest period the mode needs
	assign frame_wrap = e1_mode ? E1_N : LOOP_N;
	assign frame_last = (frame_count == frame_wrap - 7'h01);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			frame_count <= 7'h00;
		else if (frame_pulse)
			frame_count <= frame_last ? 7'h00 : frame_count + 7'h01;
	end

	// Boundaries fall on the frame that closes each period
	assign align_due = frame_pulse &&
		((frame_count % ALIGN_N) == ALIGN_N - 7'h01); // R7
	assign mf_due = frame_pulse && (e1_mode ?
		((frame_count % E1_N) == E1_N - 7'h01) :
		esf_mode ?
		((frame_count % ESF_N) == ESF_N - 7'h01) :
		((frame_count % D4_N) == D4_N - 7'h01)); // R8

	// Loss of tx clock detection
	txsi_clock_monitor u_clkmon (
		.pclk(pclk),
		.presetn(presetn),
		.tx_clock_input(tx_clock_input),
		.lost(clk_lost_level),
		.lost_rise(clk_lost_rise),
		.restored(clk_restored)
	);

	// Alarm follows the live condition, not the clearable flag
	assign tx_clock_lost = clk_lost_level && mode_ctl[`TXSI_MODE_ALARM_EN]; // R10 R11

	// Framing event sources; mode-specific ones gated by mode
	assign set_ls1[`TXSI_LS1_FULL] = store_drop; // R3
	assign set_ls1[`TXSI_LS1_EMPTY] = store_repeat; // R4
	assign set_ls1[`TXSI_LS1_SLIP] = store_drop || store_repeat; // R5
	assign set_ls1[`TXSI_LS1_LOOPMF] = !e1_mode && mode_ctl[`TXSI_MODE_LOOPMF] &&
		frame_pulse && frame_last; // R6 R25
	assign set_ls1[`TXSI_LS1_ALIGN] = e1_mode && align_due; // R7 R25
	assign set_ls1[`TXSI_LS1_MF] = mf_due; // R8
	assign set_ls1[`TXSI_LS1_CLKOK] = clk_restored; // R9
	assign set_ls1[`TXSI_LS1_CLKLOST] = clk_lost_rise; // R10

	// Hdlc fifo conditions
	assign threshold = (watermark_select == 2'h0) ? `TXSI_WM_0 :
		(watermark_select == 2'h1) ? `TXSI_WM_1 :
		(watermark_select == 2'h2) ? `TXSI_WM_2 : `TXSI_WM_3; // R22
	assign below_watermark_now = fifo_level < threshold;
	assign not_full_now = fifo_level != `TXSI_FIFO_DEPTH;
	assign underrun = message_open && (fifo_level == 7'h00) && !fifo_was_empty;

	// Edge history for the hdlc conditions
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			below_prev <= 1'b0;
			not_full_prev <= 1'b0;
			fifo_was_empty <= 1'b0;
			abort_send <= 1'b0;
		end
		else
		begin
			below_prev <= below_watermark_now;
			not_full_prev <= not_full_now;
			fifo_was_empty <= fifo_level == 7'h00;
			abort_send <= underrun; // R14
		end
	end

	// Hdlc event sources
	assign set_ls2[7:5] = 3'h0;
	assign set_ls2[`TXSI_LS2_DLEMPTY] = !e1_mode && data_link_shift_done; // R13 R25
	assign set_ls2[`TXSI_LS2_UNDERRUN] = underrun; // R14
	assign set_ls2[`TXSI_LS2_MSGEND] = message_done; // R15
	assign set_ls2[`TXSI_LS2_BELOWWM] = below_watermark_now && !below_prev; // R16
	assign set_ls2[`TXSI_LS2_NOTFULL] = not_full_now && !not_full_prev; // R17

	// Synchronizer: live hunting bit plus a sticky copy
	assign sync_hunting_now = tx_synchronizer_enable && sync_searching; // R18 R23
	assign set_ls3 = {7'h00, sync_hunting_now}; // R18

	// Write-one-to-clear strobes, one per status register
	assign clr_ls1 = (wr && idx == `TXSI_IDX_LS1) ? pwdata[7:0] : 8'h00;
	assign clr_ls2 = (wr && idx == `TXSI_IDX_LS2) ? pwdata[7:0] : 8'h00;
	assign clr_ls3 = (wr && idx == `TXSI_IDX_LS3) ? {7'h00, pwdata[0]} : 8'h00;

	// Sticky flags
	txsi_event_latch u_ls1 (
		.pclk(pclk),
		.presetn(presetn),
		.set(set_ls1),
		.clr(clr_ls1),
		.flag(tx_latched_status_framing)
	); // R21 R24
	txsi_event_latch u_ls2 (
		.pclk(pclk),
		.presetn(presetn),
		.set(set_ls2),
		.clr(clr_ls2),
		.flag(tx_latched_status_hdlc)
	); // R21 R24
	txsi_event_latch u_ls3 (
		.pclk(pclk),
		.presetn(presetn),
		.set(set_ls3),
		.clr(clr_ls3),
		.flag(ls3_latched)
	); // R18

	// Live bit never reaches the interrupt; only the latched bit is masked in
	assign tx_status_synchronizer = {6'h00, sync_hunting_now, ls3_latched[0]}; // R18 R21

	// Summary bits clear as soon as the flags or masks are serviced
	assign tx_interrupt_summary = {5'h00,
		|(ls3_latched & tx_mask_synchronizer),
		|(tx_latched_status_hdlc & tx_mask_hdlc),
		|(tx_latched_status_framing & tx_mask_framing)}; // R19 R20

	// Open-drain interrupt: pull low while anything unmasked is pending
	assign irq_out_n_o = 1'b0;
	assign irq_out_n_oe = |tx_interrupt_summary; // R12 R24

	// Read mux, captured in the setup phase so data is ready in the access phase
	always @*
	begin
		next_read = 8'h00;
		if (idx == `TXSI_IDX_WMARK)
			next_read = {6'h00, watermark_select};
		else if (idx == `TXSI_IDX_SYNCC)
			next_read = {4'h0, sync_ctl};
		else if (idx == `TXSI_IDX_LS1)
			next_read = tx_latched_status_framing;
		else if (idx == `TXSI_IDX_LS2)
			next_read = tx_latched_status_hdlc;
		else if (idx == `TXSI_IDX_LS3)
			next_read = tx_status_synchronizer;
		else if (idx == `TXSI_IDX_SUM)
			next_read = tx_interrupt_summary;
		else if (idx == `TXSI_IDX_MASK1)
			next_read = tx_mask_framing;
		else if (idx == `TXSI_IDX_MASK2)
			next_read = tx_mask_hdlc;
		else if (idx == `TXSI_IDX_MASK3)
			next_read = tx_mask_synchronizer;
		else if (idx == `TXSI_IDX_MODE)
			next_read = {4'h0, mode_ctl};
	end

	// Read data and error flag register on the setup cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= pwrite ? 32'h00000000 : {24'h000000, next_read};
			pslverr <= !mapped;
		end
	end

endmodule

`default_nettype wire

//--- txsi_top_monitor.sv
// Concurrent checks on the ports of the tx status block
`default_nettype none
`include "txsi_defines.vh"
module txsi_top_monitor (
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Datapath inputs
	input wire logic tx_clock_input,
	input wire logic [6:0] fifo_level,
	input wire logic message_open,
	// Design outputs
	input wire logic tx_synchronizer_enable,
	input wire logic auto_resync_enable,
	input wire logic resync_start,
	input wire logic abort_send,
	input wire logic tx_clock_lost,
	input wire logic irq_out_n_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] sync_q;
	logic [7:0] quiet;
	wire wr_now = psel && penable && pwrite;
	wire wr_sync = wr_now && paddr[11:2] == `TXSI_IDX_SYNCC;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of sync control, written at the same edge as the design's copy
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sync_q <= 4'h0;
		else if (wr_sync)
			sync_q <= pwdata[3:0];
	// Quiet cycles of the tx clock pin; saturates so a long loss never wraps
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			quiet <= 8'h00;
		else if (!$stable(tx_clock_input))
			quiet <= 8'h00;
		else if (quiet != 8'hff)
			quiet <= quiet + 8'h01;
	sequence resync_req;
		wr_sync && pwdata[0] && pwdata[2] && !sync_q[0];
	endsequence
	sequence underrun;
		fifo_level == 7'h00 && $past(fifo_level) != 7'h00 && message_open;
	endsequence
	sync_enable_a: assert property (tx_synchronizer_enable == sync_q[2])
		else $error("synchronizer enable differs from control");
	auto_resync_a: assert property (auto_resync_enable == (sync_q[2] && !sync_q[1]))
		else $error("auto resync level wrong");
	resync_start_a: assert property (resync_req |-> ##[1:3] resync_start)
		else $error("resync request gave no start pulse");
	resync_pulse_a: assert property (resync_start |=> !resync_start)
		else $error("resync start longer than one cycle");
	abort_send_a: assert property (underrun |-> ##[1:2] abort_send)
		else $error("underrun without abort");
	abort_pulse_a: assert property (abort_send |=> !abort_send)
		else $error("abort longer than one cycle");
	alarm_rise_a: assert property ($rose(tx_clock_lost) |-> quiet >= 8'd190)
		else $error("clock alarm before three quiet periods");
	alarm_hold_a: assert property (tx_clock_lost && $stable(tx_clock_input) && !(psel && pwrite)
		|=> tx_clock_lost)
		else $error("clock alarm dropped while clock absent");
	irq_sticky_a: assert property (irq_out_n_oe && !wr_now |=> irq_out_n_oe)
		else $error("interrupt released without a write");
endmodule
bind txsi_top txsi_top_monitor txsi_top_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.tx_clock_input(tx_clock_input), .fifo_level(fifo_level), .message_open(message_open),
	.tx_synchronizer_enable(tx_synchronizer_enable), .auto_resync_enable(auto_resync_enable),
	.resync_start(resync_start), .abort_send(abort_send), .tx_clock_lost(tx_clock_lost),
	.irq_out_n_oe(irq_out_n_oe));
`default_nettype wire

//--- txsi_top_tb.sv
// Self-checking bench for the tx status block over APB
`default_nettype none
`include "txsi_defines.vh"
module txsi_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, tclk_run, tx_clock_input, message_open;
	logic sync_searching, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [6:0] fifo_level;
	logic [4:0] ev;
	wire logic store_drop, store_repeat, frame_pulse, data_link_shift_done, message_done;
	logic tx_synchronizer_enable, auto_resync_enable, resync_start, crc4_search;
	logic abort_send, tx_clock_lost, irq_out_n_o, irq_out_n_oe;
	int n_mismatch = 0, checks = 0, n_resync = 0;
	logic [9:0] regs [7] = '{`TXSI_IDX_LS1, `TXSI_IDX_LS2, `TXSI_IDX_LS3, `TXSI_IDX_SUM,
		`TXSI_IDX_MASK1, `TXSI_IDX_MASK2, `TXSI_IDX_MASK3};
	logic [6:0] wm [4] = '{7'h04, 7'h10, 7'h20, 7'h30};
	assign {message_done, data_link_shift_done, frame_pulse, store_repeat, store_drop} = ev;
	txsi_top txsi_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .store_drop(store_drop), .store_repeat(store_repeat),
		.frame_pulse(frame_pulse), .tx_clock_input(tx_clock_input),
		.data_link_shift_done(data_link_shift_done), .fifo_level(fifo_level),
		.message_open(message_open), .message_done(message_done),
		.sync_searching(sync_searching), .tx_synchronizer_enable(tx_synchronizer_enable),
		.auto_resync_enable(auto_resync_enable), .resync_start(resync_start),
		.crc4_search(crc4_search), .abort_send(abort_send), .tx_clock_lost(tx_clock_lost),
		.irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe));
	// Free-running 100 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	// Line clock toggles every cycle unless a loss is being staged
	always @(posedge pclk)
		if (tclk_run)
			tx_clock_input <= ~tx_clock_input;
	// Resync pulses are counted, since one write must give exactly one
	always @(posedge pclk)
		if (resync_start === 1'h1)
			n_resync <= n_resync + 1;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask
	// One APB transfer, held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge pclk);
		{psel, penable, pwrite} <= {1'h1, 1'h0, w};
		paddr <= {i, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] x);
		xfer(1'h0, i, 8'h00);
		chk($sformatf("reg %h", i), q, {24'h000000, x});
	endtask
	// Event pulses one cycle wide, one idle cycle apart
	task automatic pulse(input int b, input int n);
		repeat (n)
		begin
			@(posedge pclk) ev[b] <= 1'h1;
			@(posedge pclk) ev[b] <= 1'h0;
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog, far beyond the under a thousand cycles the sequence needs
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		test_done;
	end
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, message_open, sync_searching} = 6'h00;
		{tclk_run, tx_clock_input, ev, paddr, pwdata, fifo_level} = {2'h2, 5'h0, 44'h0, 7'h40};
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		foreach (regs[k]) rd(regs[k], 8'h00);
		xfer(1'h0, 10'h100, 8'h00);
		chk("unmapped error", e, 1'h1);
		xfer(1'h1, `TXSI_IDX_MASK2, 8'hff);
		rd(`TXSI_IDX_MASK2, 8'h1f);
		xfer(1'h1, `TXSI_IDX_MASK3, 8'hff);
		rd(`TXSI_IDX_MASK3, 8'h01);
		pulse(0, 1);
		rd(`TXSI_IDX_LS1, 8'ha0);
		pulse(1, 1);
		#1 chk("irq", irq_out_n_oe, 1'h0);
		rd(`TXSI_IDX_LS1, 8'he0);
		rd(`TXSI_IDX_SUM, 8'h00);
		xfer(1'h1, `TXSI_IDX_MASK1, 8'hff);
		#1 chk("irq", irq_out_n_oe, 1'h1);
		rd(`TXSI_IDX_SUM, 8'h01);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h20);
		rd(`TXSI_IDX_LS1, 8'hc0);
		xfer(1'h1, `TXSI_IDX_LS1, 8'hc0);
		#1 chk("irq", irq_out_n_oe, 1'h0);
		xfer(1'h1, `TXSI_IDX_MODE, 8'h08);
		tclk_run <= 1'h0;
		repeat (200) @(posedge pclk);
		#1 chk("alarm", tx_clock_lost, 1'h1);
		chk("irq", irq_out_n_oe, 1'h1);
		rd(`TXSI_IDX_LS1, 8'h01);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h01);
		#1 chk("irq", irq_out_n_oe, 1'h0);
		chk("alarm", tx_clock_lost, 1'h1);
		tclk_run <= 1'h1;
		repeat (3) @(posedge pclk);
		#1 chk("alarm", tx_clock_lost, 1'h0);
		rd(`TXSI_IDX_LS1, 8'h02);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h02);
		xfer(1'h1, `TXSI_IDX_MODE, 8'h0c);
		pulse(2, 11);
		rd(`TXSI_IDX_LS1, 8'h00);
		pulse(2, 1);
		rd(`TXSI_IDX_LS1, 8'h04);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h04);
		pulse(2, 60);
		rd(`TXSI_IDX_LS1, 8'h14);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h14);
		xfer(1'h1, `TXSI_IDX_MODE, 8'h01);
		pulse(2, 1);
		rd(`TXSI_IDX_LS1, 8'h00);
		pulse(2, 1);
		rd(`TXSI_IDX_LS1, 8'h08);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h08);
		pulse(2, 14);
		rd(`TXSI_IDX_LS1, 8'h0c);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h0c);
		xfer(1'h1, `TXSI_IDX_MODE, 8'h02);
		pulse(2, 24);
		rd(`TXSI_IDX_LS1, 8'h04);
		xfer(1'h1, `TXSI_IDX_LS1, 8'h04);
		xfer(1'h1, `TXSI_IDX_MODE, 8'h00);
		fifo_level <= 7'h3f;
		rd(`TXSI_IDX_LS2, 8'h01);
		xfer(1'h1, `TXSI_IDX_LS2, 8'h01);
		for (int c = 0; c < 4; c++)
		begin
			xfer(1'h1, `TXSI_IDX_WMARK, c[7:0]);
			fifo_level <= wm[c];
			rd(`TXSI_IDX_LS2, 8'h00);
			fifo_level <= wm[c] - 7'h01;
			rd(`TXSI_IDX_LS2, 8'h02);
			xfer(1'h1, `TXSI_IDX_LS2, 8'h02);
		end
		fifo_level <= 7'h01;
		message_open <= 1'h1;
		xfer(1'h1, `TXSI_IDX_LS2, 8'h1f);
		fifo_level <= 7'h00;
		pulse(3, 1);
		pulse(4, 1);
		rd(`TXSI_IDX_LS2, 8'h1c);
		rd(`TXSI_IDX_SUM, 8'h02);
		{fifo_level, message_open} <= {7'h3f, 1'h0};
		xfer(1'h1, `TXSI_IDX_LS2, 8'h1f);
		xfer(1'h1, `TXSI_IDX_MODE, 8'h01);
		pulse(3, 1);
		rd(`TXSI_IDX_LS2, 8'h00);
		sync_searching <= 1'h1;
		rd(`TXSI_IDX_LS3, 8'h00);
		xfer(1'h1, `TXSI_IDX_SYNCC, 8'h04);
		rd(`TXSI_IDX_LS3, 8'h03);
		rd(`TXSI_IDX_SUM, 8'h04);
		sync_searching <= 1'h0;
		xfer(1'h1, `TXSI_IDX_LS3, 8'h01);
		rd(`TXSI_IDX_LS3, 8'h00);
		#1 chk("irq", irq_out_n_oe, 1'h0);
		chk("auto", auto_resync_enable, 1'h1);
		xfer(1'h1, `TXSI_IDX_SYNCC, 8'h0c);
		#1 chk("crc4", crc4_search, 1'h1);
		xfer(1'h1, `TXSI_IDX_SYNCC, 8'h06);
		#1 chk("auto", auto_resync_enable, 1'h0);
		chk("crc4", crc4_search, 1'h0);
		xfer(1'h1, `TXSI_IDX_SYNCC, 8'h05);
		xfer(1'h1, `TXSI_IDX_SYNCC, 8'h05);
		xfer(1'h1, `TXSI_IDX_SYNCC, 8'h04);
		xfer(1'h1, `TXSI_IDX_SYNCC, 8'h05);
		repeat (4) @(posedge pclk);
		chk("resync", n_resync, 32'h2);
		test_done;
	end
endmodule
`default_nettype wire
